// *** design/twt_defines.svh ***
// Register offsets, field positions and timing counts of the two-wire target.
`ifndef TWT_DEFINES_SVH
`define TWT_DEFINES_SVH
`define TWT_ADR_HI 2'h0
`define TWT_IDX_CRX 4'h0
`define TWT_IDX_CTL 4'h1
`define TWT_IDX_STA 4'h2
`define TWT_IDX_ID 4'h3
`define TWT_IDX_TX 4'h4
`define TWT_IDX_RX 4'h5
`define TWT_IDX_MASK 4'h6
`define TWT_IDX_INTERRUPT_ENABLE_FIRST 4'h7
`define TWT_IDX_INTERRUPT_ENABLE_SECOND 4'h8
`define TWT_IDX_SEL 4'h9
`define TWT_CTL_EN 7
`define TWT_CTL_PINSEL 6
`define TWT_CTL_ACK 5
`define TWT_F_TX 0
`define TWT_F_RX 1
`define TWT_F_DONE 2
`define TWT_F_ADDR 3
`define TWT_F_TMO 4
`define TWT_INTERRUPT_ENABLE_FIRST_GLOBAL 7
`define TWT_INTERRUPT_ENABLE_SECOND_BUS0 2
`define TWT_INTERRUPT_ENABLE_SECOND_BUS1 3
`define TWT_SEL_MOD 0
`define TWT_SEL_WAKE0 1
`define TWT_SEL_WAKE1 2
`define TWT_BITS 4'h8
`define TWT_LAST_TX 4'h7
`define TWT_TIMEOUT_MS 25
`define TWT_CLK_HZ 100000000
`define TWT_TMO_W 22
`define TWT_BUS1_BASE 4
`define TWT_ALT_BASE 2
`endif

// *** design/twt_pkg.sv ***
// Types shared by the two-wire target: engine states and the registered state record.
`include "twt_defines.svh"
package twt_pkg;
  typedef enum logic [8:0] {
    TWT_IDLE = 9'h001, TWT_ADDR = 9'h002, TWT_AACK = 9'h004,
    TWT_RX = 9'h008, TWT_RXST = 9'h010, TWT_RXACK = 9'h020,
    TWT_TXLD = 9'h040, TWT_TX = 9'h080, TWT_TXACK = 9'h100
  } twt_st_t;
  typedef struct packed {
    twt_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] rxb;
    logic dsda;
    logic hscl;
    logic [`TWT_TMO_W-1:0] tmo;
  } twt_eng_t;
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [1:0] scl_p;
    logic [1:0] sda_p;
    logic [1:0][7:0] ctl;
    logic [1:0][7:0] id;
    logic [1:0][7:0] mask;
    logic [1:0][7:0] tx;
    logic [1:0][7:0] rx;
    logic [1:0][7:0] crx;
    logic [1:0][4:0] flg;
    logic [1:0] rw;
    logic [7:0] interrupt_enable_first;
    logic [7:0] interrupt_enable_second;
    logic [7:0] sel;
    twt_eng_t [1:0] eng;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic wake;
    logic [5:0] oe;
    logic [5:0] pout;
  } twt_state_t;
endpackage

// *** design/twt_target.sv ***
// Two-wire bus target pair with ID mask, clock stretching and Wishbone registers.
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "twt_defines.svh"

// What this block does
// [RL1] Controller receive byte stored on read command.
// [RL2] Disabled target drives neither bus line.
// [RL3] Pin select routes lines to alternate pair.
// [RL4] Receive acknowledge driven only when allowed.
// [RL5] Each flag interrupts only when enabled.
// [RL6] Status shows live clock and data levels.
// [RL7] Matched address direction bit copied to status.
// [RL8] Stretch over 25 ms: timeout, release lines.
// [RL9] Address match sets flag, stores address word.
// [RL10] Pending address flag blocks overwrite, stretches clock; here only a received data byte waits on it, a transmit load does not.
// [RL11] Stop or transmit NACK sets done flag.
// [RL12] Byte received flag set; no overwrite while set.
// [RL13] Transmit load sets flag; stretch while set.
// [RL14] Flags clear by writing one only.
// [RL15] Compare upper seven address bits with ID.
// [RL16] Zero mask bits excluded from comparison.
// [RL17] Stretch until transmit flag clear, then load.
// [RL18] Stretch until receive flag clear, then copy.
// [RL19] Software enables transmit interrupt after first load.
// [RL20] Global enable blocks every interrupt.
// [RL21] Per-module enable gates that module's interrupts.
// [RL22] Module select picks register set at shared addresses.
// [RL23] Wake allowed when line low and enabled.
// [RL24] Bus lines synchronised before edge detection.
module twt_target
  import twt_pkg::*;
#(
  parameter int TIMEOUT_CYC = (`TWT_CLK_HZ / 1000) * `TWT_TIMEOUT_MS
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Controller receive bytes, one lane per module.
  input wire logic [1:0] ctl_rx_valid_i,
  input wire logic [15:0] ctl_rx_data_i,
  // Port pins, open drain.
  input wire logic [5:0] pin_i,
  output logic [5:0] pin_o,
  output logic [5:0] pin_oe_o,
  // System events.
  output logic irq_o,
  output logic wake_o
);

  twt_state_t r_q;
  twt_state_t r_d;

  function automatic int pin_base(input logic b, input logic alt);
    if (b) begin
      return `TWT_BUS1_BASE;
    end
    return alt ? `TWT_ALT_BASE : 0;
  endfunction

  function automatic logic line_lvl(input logic [5:0] s, input logic b, input logic alt,
                                    input logic dat);
    return s[pin_base(b, alt) + int'(dat)]; // [RL3]
  endfunction

  function automatic logic id_match(input logic [7:0] a, input logic [7:0] id,
                                    input logic [7:0] mk);
    return ((a[7:1] ^ id[7:1]) & mk[7:1]) == 7'h00; // [RL15] [RL16]
  endfunction

  function automatic logic [7:0] reg_read(input twt_state_t s, input logic [3:0] i,
                                          input logic mm, input logic cl, input logic da);
    case (i)
      `TWT_IDX_CRX: return s.crx[mm];
      `TWT_IDX_CTL: return s.ctl[mm];
      `TWT_IDX_STA: return {cl, da, s.rw[mm], s.flg[mm]}; // [RL6] [RL7]
      `TWT_IDX_ID: return s.id[mm];
      `TWT_IDX_TX: return s.tx[mm];
      `TWT_IDX_RX: return s.rx[mm];
      `TWT_IDX_MASK: return s.mask[mm];
      `TWT_IDX_INTERRUPT_ENABLE_FIRST: return s.interrupt_enable_first;
      `TWT_IDX_INTERRUPT_ENABLE_SECOND: return s.interrupt_enable_second;
      `TWT_IDX_SEL: return s.sel;
      default: return 8'h00;
    endcase
  endfunction

  logic req;
  logic m;
  logic hit;
  logic [3:0] idx;
  logic [1:0][4:0] clr;
  logic [4:0] set;
  twt_eng_t e;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic alt0;
  logic [1:0] any;
  logic [1:0] low;
  int base;

  always_comb begin
    r_d = r_q;
    req = 1'b0;
    m = 1'b0;
    hit = 1'b0;
    idx = 4'h0;
    clr = '0;
    set = 5'h00;
    e = r_q.eng[0];
    scl = 1'b1;
    sda = 1'b1;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    any = 2'h0;
    low = 2'h0;
    base = 0;
    alt0 = r_q.ctl[0][`TWT_CTL_PINSEL];

    // Only the second stage is looked at; the first just settles. [RL24]
    r_d.sync1 = pin_i;
    r_d.sync2 = r_q.sync1;

    // Every strobe is answered one cycle later, unmapped ones with zero data.
    req = wb_cyc_i & wb_stb_i & ~r_q.ack;
    r_d.ack = req;
    m = r_q.sel[`TWT_SEL_MOD]; // [RL22]
    idx = wb_adr_i[5:2];
    hit = wb_adr_i[7:6] == `TWT_ADR_HI;
    if (req) begin
      r_d.dat = {24'h000000, hit ? reg_read(r_q, idx, m,
                 line_lvl(r_q.sync2, m, alt0, 1'b0),
                 line_lvl(r_q.sync2, m, alt0, 1'b1)) : 8'h00};
      if (wb_we_i && wb_sel_i[0] && hit) begin
        case (idx)
          `TWT_IDX_CTL: r_d.ctl[m] = wb_dat_i[7:0];
          `TWT_IDX_STA: clr[m] = wb_dat_i[4:0]; // [RL14]
          `TWT_IDX_ID: r_d.id[m] = wb_dat_i[7:0];
          `TWT_IDX_TX: r_d.tx[m] = wb_dat_i[7:0];
          `TWT_IDX_MASK: r_d.mask[m] = wb_dat_i[7:0];
          `TWT_IDX_INTERRUPT_ENABLE_FIRST: r_d.interrupt_enable_first = wb_dat_i[7:0];
          `TWT_IDX_INTERRUPT_ENABLE_SECOND: r_d.interrupt_enable_second = wb_dat_i[7:0];
          `TWT_IDX_SEL: r_d.sel = wb_dat_i[7:0];
          default: r_d.dat = r_d.dat;
        endcase
      end
    end

    for (int b = 0; b < 2; b++) begin
      set = 5'h00;
      e = r_q.eng[b];
      scl = line_lvl(r_q.sync2, b[0], alt0, 1'b0);
      sda = line_lvl(r_q.sync2, b[0], alt0, 1'b1);
      low[b] = ~scl | ~sda;
      r_d.scl_p[b] = scl;
      r_d.sda_p[b] = sda;
      rise = scl & ~r_q.scl_p[b];
      fall = ~scl & r_q.scl_p[b];
      start = scl & r_q.scl_p[b] & r_q.sda_p[b] & ~sda;
      stop = scl & r_q.scl_p[b] & ~r_q.sda_p[b] & sda;
      if (ctl_rx_valid_i[b]) begin
        r_d.crx[b] = ctl_rx_data_i[8*b +: 8]; // [RL1]
      end
      case (e.st)
        TWT_IDLE: begin
          e.dsda = 1'b0;
          e.hscl = 1'b0;
        end
        TWT_ADDR: begin
          if (rise) begin
            e.sh = {e.sh[6:0], sda};
            e.cnt = e.cnt + 4'h1;
          end else if (fall && e.cnt == `TWT_BITS) begin
            if (id_match(e.sh, r_q.id[b], r_q.mask[b])) begin // [RL15]
              set[`TWT_F_ADDR] = 1'b1; // [RL9]
              r_d.rx[b] = e.sh; // [RL9]
              r_d.rw[b] = e.sh[0]; // [RL7]
              e.dsda = 1'b1;
              e.st = TWT_AACK;
            end else begin
              e.st = TWT_IDLE; // [RL15]
            end
          end
        end
        TWT_AACK: begin
          if (fall) begin
            e.dsda = 1'b0;
            e.cnt = 4'h0;
            e.st = r_q.rw[b] ? TWT_TXLD : TWT_RX;
          end
        end
        TWT_TXLD: begin
          if (r_q.flg[b][`TWT_F_TX]) begin
            e.hscl = 1'b1; // [RL13] [RL17]
          end else begin
            // The clock stays held one more cycle so the data line settles before it rises.
            e.sh = r_q.tx[b]; // [RL17]
            set[`TWT_F_TX] = 1'b1; // [RL13]
            e.dsda = ~r_q.tx[b][7];
            e.cnt = 4'h0;
            e.st = TWT_TX;
          end
        end
        TWT_TX: begin
          e.hscl = 1'b0;
          if (fall) begin
            if (e.cnt == `TWT_LAST_TX) begin
              e.dsda = 1'b0;
              e.st = TWT_TXACK;
            end else begin
              e.cnt = e.cnt + 4'h1;
              e.sh = {e.sh[6:0], 1'b0};
              e.dsda = ~e.sh[7];
            end
          end
        end
        TWT_TXACK: begin
          if (rise && sda) begin
            set[`TWT_F_DONE] = 1'b1; // [RL11]
            e.st = TWT_IDLE;
          end else if (fall) begin
            e.st = TWT_TXLD;
          end
        end
        TWT_RX: begin
          if (rise) begin
            e.sh = {e.sh[6:0], sda};
            e.cnt = e.cnt + 4'h1;
          end else if (fall && e.cnt == `TWT_BITS) begin
            e.rxb = e.sh;
            e.st = TWT_RXST;
          end
        end
        TWT_RXST: begin
          if (r_q.flg[b][`TWT_F_RX] || r_q.flg[b][`TWT_F_ADDR]) begin
            e.hscl = 1'b1; // [RL10] [RL12] [RL18]
          end else begin
            r_d.rx[b] = e.rxb; // [RL18]
            set[`TWT_F_RX] = 1'b1; // [RL12]
            e.dsda = r_q.ctl[b][`TWT_CTL_ACK]; // [RL4]
            e.st = TWT_RXACK;
          end
        end
        TWT_RXACK: begin
          e.hscl = 1'b0;
          if (fall) begin
            e.dsda = 1'b0;
            e.cnt = 4'h0;
            e.st = TWT_RX;
          end
        end
        default: begin
          e.st = TWT_IDLE;
        end
      endcase
      if (start) begin
        e.st = TWT_ADDR;
        e.cnt = 4'h0;
        e.dsda = 1'b0;
        e.hscl = 1'b0;
      end else if (stop) begin
        if (r_q.eng[b].st != TWT_IDLE && r_q.eng[b].st != TWT_ADDR) begin
          set[`TWT_F_DONE] = 1'b1; // [RL11]
        end
        e.st = TWT_IDLE;
        e.dsda = 1'b0;
        e.hscl = 1'b0;
      end
      // The count only runs while this target itself holds the clock low.
      if (r_q.eng[b].hscl && e.hscl) begin
        if (r_q.eng[b].tmo == `TWT_TMO_W'(TIMEOUT_CYC)) begin
          set[`TWT_F_TMO] = 1'b1; // [RL8]
          e.st = TWT_IDLE;
          e.dsda = 1'b0;
          e.hscl = 1'b0;
          e.tmo = '0;
        end else begin
          e.tmo = r_q.eng[b].tmo + `TWT_TMO_W'(1);
        end
      end else begin
        e.tmo = '0;
      end
      if (!r_q.ctl[b][`TWT_CTL_EN]) begin
        e.st = TWT_IDLE; // [RL2]
        e.dsda = 1'b0;
        e.hscl = 1'b0;
        e.tmo = '0;
        set = 5'h00;
      end
      r_d.eng[b] = e;
      // A hardware set in the same cycle as a software clear wins.
      r_d.flg[b] = (r_q.flg[b] & ~clr[b]) | set; // [RL14]
      any[b] = |(r_d.flg[b] & r_d.ctl[b][4:0]); // [RL5]
    end

    r_d.oe = 6'h00;
    for (int b = 0; b < 2; b++) begin
      base = pin_base(b[0], r_d.ctl[0][`TWT_CTL_PINSEL]); // [RL3]
      r_d.oe[base] = r_d.ctl[b][`TWT_CTL_EN] & r_d.eng[b].hscl; // [RL2]
      r_d.oe[base + 1] = r_d.ctl[b][`TWT_CTL_EN] & r_d.eng[b].dsda; // [RL2]
    end
    r_d.pout = 6'h00;
    r_d.irq = r_d.interrupt_enable_first[`TWT_INTERRUPT_ENABLE_FIRST_GLOBAL] & // [RL20]
              ((r_d.interrupt_enable_second[`TWT_INTERRUPT_ENABLE_SECOND_BUS0] & any[0]) | // [RL21]
               (r_d.interrupt_enable_second[`TWT_INTERRUPT_ENABLE_SECOND_BUS1] & any[1])); // [RL21]
    r_d.wake = (r_d.sel[`TWT_SEL_WAKE0] & low[0]) | // [RL23]
               (r_d.sel[`TWT_SEL_WAKE1] & low[1]); // [RL23]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q <= '0;
      r_q.sync1 <= '1;
      r_q.sync2 <= '1;
      r_q.scl_p <= '1;
      r_q.sda_p <= '1;
      r_q.eng[0].st <= TWT_IDLE;
      r_q.eng[1].st <= TWT_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  assign wb_dat_o = r_q.dat;
  assign wb_ack_o = r_q.ack;
  assign irq_o = r_q.irq;
  assign wake_o = r_q.wake;
  assign pin_oe_o = r_q.oe;
  assign pin_o = r_q.pout;

endmodule
`default_nettype wire

// *** test/twt_checker.sv ***
// Port assertions for the two-wire target, bound into the design.
`timescale 1ns/1ns
`default_nettype none
module twt_checker #(
  parameter int TIMEOUT_CYC = 2500000
) (
  // Clock, reset and register bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Pins and events.
  input wire logic [5:0] pin_oe_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  typedef struct packed {
    logic [7:0] interrupt_enable_first;
    logic [7:0] interrupt_enable_second;
    logic [7:0] sel;
    logic en0;
    logic [31:0] cnt;
  } twt_chk_t;
  twt_chk_t q, d;
  logic wr;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // Shadow copies of the enables let outputs be judged without bus reads.
  always_comb begin
    d = q;
    d.cnt = pin_oe_o[0] ? q.cnt + 32'h1 : 32'h0;
    if (wr && wb_adr_i == 8'h1C) d.interrupt_enable_first = wb_dat_i[7:0];
    if (wr && wb_adr_i == 8'h20) d.interrupt_enable_second = wb_dat_i[7:0];
    if (wr && wb_adr_i == 8'h24) d.sel = wb_dat_i[7:0];
    if (wr && wb_adr_i == 8'h04 && !q.sel[0]) d.en0 = wb_dat_i[7];
    if (rst_i) d = '0;
  end
  always_ff @(posedge clk_i) begin
    q <= d;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held too long");
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("request not answered");
  property p_off0; (!q.en0) [*2] |-> pin_oe_o[3:0] == 4'h0; endproperty
  a_off0: assert property (p_off0)
    else $error("disabled target drives a line");
  property p_pair; !((|pin_oe_o[1:0]) && (|pin_oe_o[3:2])); endproperty
  a_pair: assert property (p_pair)
    else $error("both pin pairs driven");
  property p_tmo; q.cnt <= TIMEOUT_CYC + 3; endproperty
  a_tmo: assert property (p_tmo)
    else $error("clock held past timeout");
  property p_glob; (q.interrupt_enable_first[7] == 1'b0) [*3] |-> !irq_o; endproperty
  a_glob: assert property (p_glob)
    else $error("request with global enable clear");
  property p_bus; (q.interrupt_enable_second[3:2] == 2'h0) [*3] |-> !irq_o; endproperty
  a_bus: assert property (p_bus)
    else $error("request with both module enables clear");
  property p_wake; (q.sel[2:1] == 2'h0) [*3] |-> !wake_o; endproperty
  a_wake: assert property (p_wake)
    else $error("wake without wake enable");
endmodule
bind twt_target twt_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o), .wake_o(wake_o));
`default_nettype wire

// *** test/twt_ctl_model.sv ***
// Behavioural bus controller on the far side of the two-wire link.
`timescale 1ns/1ns
`default_nettype none
module twt_ctl_model (
  // Resolved lines.
  input wire logic scl_i,
  input wire logic sda_i,
  // Pulls, high pulls the line low.
  output logic scl_dn_o,
  output logic sda_dn_o
);
  int stalls = 0;
  initial begin
    scl_dn_o = 1'b0;
    sda_dn_o = 1'b0;
  end
  // Every change lands 2 ns after a system clock edge, never on it.
  task automatic pull_sda(input logic v);
    #2 sda_dn_o = v;
    #8;
  endtask
  // The wait on a stretched clock is bounded so a stuck target cannot hang us.
  task automatic bit9(input logic b, output logic r);
    int n;
    n = 0;
    #2 sda_dn_o = !b;
    #30 scl_dn_o = 1'b0;
    while (!scl_i && n < 5000) begin
      #10 n++;
    end
    if (n >= 5000) begin
      stalls++;
    end
    #20 r = sda_i;
    #10 scl_dn_o = 1'b1;
    #18;
  endtask
  task automatic byte9(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      bit9(w[i], r[i]);
    end
  endtask
  task automatic start();
    #2 sda_dn_o = 1'b0;
    #20 scl_dn_o = 1'b0;
    #40 sda_dn_o = 1'b1;
    #40 scl_dn_o = 1'b1;
    #18;
  endtask
  task automatic stop();
    #2 sda_dn_o = 1'b1;
    #20 scl_dn_o = 1'b0;
    #40 sda_dn_o = 1'b0;
    #38;
  endtask
endmodule
`default_nettype wire

// *** test/test_two_wire_target_with_id_mask.sv ***
// Self-checking bench for the two-wire target: register tasks and link scenarios.
`timescale 1ns/1ns
`default_nettype none
`define TWT_CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_two_wire_target_with_id_mask;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [1:0] crv = 2'h0;
  logic [15:0] crd = 16'h0;
  logic [31:0] rdat;
  logic [5:0] oe;
  logic [5:0] po;
  logic ack, irq, wake;
  int failures = 0;
  int check_count = 0;
  wire logic scl_dn, sda_dn, scl, sda;
  assign scl = !(scl_dn | oe[0] | oe[2] | oe[4]);
  assign sda = !(sda_dn | oe[1] | oe[3] | oe[5]);
  twt_target #(.TIMEOUT_CYC(200)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ctl_rx_valid_i(crv), .ctl_rx_data_i(crd),
    .pin_i({sda, scl, sda, scl, sda, scl}), .pin_o(po), .pin_oe_o(oe), .irq_o(irq),
    .wake_o(wake));
  twt_ctl_model m (.scl_i(scl), .sda_i(sda), .scl_dn_o(scl_dn), .sda_dn_o(sda_dn));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v,
                    output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      give_verdict();
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] r;
    wb(1'b1, a, v, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] k, input logic [7:0] e);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    `TWT_CHK(r & k, e)
  endtask
  task automatic wait_oe(input int i);
    int n;
    n = 0;
    while (oe[i] !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    `TWT_CHK(oe[i], 1'b1)
  endtask
  initial begin
    logic [8:0] r;
    logic [7:0] ro [4];
    logic [31:0] it [4];
    ro = '{8'h00, 8'h14, 8'h28, 8'h44};
    it = '{32'h80800400, 32'h84800401, 32'h84000400, 32'h84800800};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rc(8'(i * 4), 8'hFF, (i == 2) ? 8'hC0 : 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ro[i], 8'hFF);
      rc(ro[i], 8'hFF, 8'h00);
    end
    @(posedge clk_i);
    crv <= 2'h3;
    crd <= 16'hA55A;
    @(posedge clk_i);
    crv <= 2'h0;
    rc(8'h00, 8'hFF, 8'h5A);
    wr(8'h24, 8'h01);
    rc(8'h00, 8'hFF, 8'hA5);
    wr(8'h0C, 8'h7E);
    wr(8'h24, 8'h00);
    rc(8'h0C, 8'hFF, 8'h00);
    wr(8'h0C, 8'hA0);
    wr(8'h18, 8'hFE);
    wr(8'h04, 8'hA0);
    m.start();
    m.byte9({8'hA2, 1'b1}, r);
    `TWT_CHK(r[0], 1'b1)
    m.stop();
    rc(8'h08, 8'h3F, 8'h00);
    wr(8'h18, 8'hFC);
    m.start();
    m.byte9({8'hA2, 1'b1}, r);
    `TWT_CHK(r[0], 1'b0)
    rc(8'h08, 8'h3F, 8'h08);
    rc(8'h14, 8'hFF, 8'hA2);
    fork
      m.byte9({8'h3C, 1'b1}, r);
      begin
        wait_oe(0);
        rc(8'h14, 8'hFF, 8'hA2);
        wr(8'h08, 8'h08);
      end
    join
    `TWT_CHK(r[0], 1'b0)
    rc(8'h14, 8'hFF, 8'h3C);
    wr(8'h04, 8'h80);
    fork
      m.byte9({8'hC3, 1'b1}, r);
      begin
        wait_oe(0);
        rc(8'h14, 8'hFF, 8'h3C);
        wr(8'h08, 8'h02);
      end
    join
    `TWT_CHK(r[0], 1'b1)
    rc(8'h14, 8'hFF, 8'hC3);
    m.stop();
    rc(8'h08, 8'h3F, 8'h06);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, it[i][31:24]);
      wr(8'h1C, it[i][23:16]);
      wr(8'h20, it[i][15:8]);
      repeat (3) @(posedge clk_i);
      `TWT_CHK(irq, it[i][0])
    end
    wr(8'h08, 8'h00);
    rc(8'h08, 8'h3F, 8'h06);
    wr(8'h08, 8'h1F);
    rc(8'h08, 8'h3F, 8'h00);
    wr(8'h24, 8'h02);
    m.pull_sda(1'b1);
    repeat (5) @(posedge clk_i);
    `TWT_CHK(wake, 1'b1)
    rc(8'h08, 8'hC0, 8'h80);
    m.pull_sda(1'b0);
    repeat (5) @(posedge clk_i);
    `TWT_CHK(wake, 1'b0)
    wr(8'h10, 8'h96);
    m.start();
    m.byte9({8'hA3, 1'b1}, r);
    repeat (5) @(posedge clk_i);
    rc(8'h08, 8'h3F, 8'h29);
    m.byte9({8'hFF, 1'b0}, r);
    `TWT_CHK(r[8:1], 8'h96)
    fork
      m.byte9({8'hFF, 1'b1}, r);
      begin
        wait_oe(0);
        wr(8'h10, 8'h69);
        wr(8'h08, 8'h01);
      end
    join
    `TWT_CHK(r[8:1], 8'h69)
    repeat (5) @(posedge clk_i);
    rc(8'h08, 8'h3F, 8'h2D);
    m.stop();
    wr(8'h08, 8'h1F);
    wr(8'h04, 8'hB0);
    m.start();
    m.byte9({8'hA2, 1'b1}, r);
    m.byte9({8'h55, 1'b1}, r);
    rc(8'h08, 8'h10, 8'h10);
    m.stop();
    wr(8'h08, 8'h1F);
    wr(8'h04, 8'hE0);
    m.start();
    fork
      m.byte9({8'hA2, 1'b1}, r);
      wait_oe(3);
    join
    m.stop();
    wr(8'h08, 8'h1F);
    wr(8'h04, 8'h00);
    m.start();
    m.byte9({8'hA2, 1'b1}, r);
    `TWT_CHK(r[0], 1'b1)
    m.stop();
    rc(8'h08, 8'h3F, 8'h00);
    `TWT_CHK({po, oe}, 12'h000)
    `TWT_CHK(m.stalls, 0)
    give_verdict();
  end
endmodule
`default_nettype wire
